// File: hdl/gdio_pkg.sv
/*
 * Shared constants and types of the general digital I/O port.
 * Assumes a single system clock domain and plain strobe ports for register access.
 */
package gdio_pkg;
	localparam int GDIO_WIDTH_DEF = 8;
	localparam logic GDIO_DIR_RST = 1'b0;
	localparam logic GDIO_LATCH_RST = 1'b0;
	localparam logic GDIO_SAMPLE_RST = 1'b0;
	localparam int GDIO_IDX_W_DEF = 3;
	localparam int GDIO_ECHO_CYCLES = 1;

	typedef enum logic [1:0] {
		GDIO_REG_LATCH = 2'b00,
		GDIO_REG_DIR = 2'b01,
		GDIO_REG_SAMPLE = 2'b10
	} gdio_reg_t;
endpackage

// File: hdl/gdio_sync.sv
/*
 * Input synchroniser: a falling-edge flop standing in for a latch open while the clock is high, then a flop.
 * Assumes the latch output is read by the flop only.
 */
`timescale 1ns/1ns
module gdio_sync
	import gdio_pkg::*;
#(
	parameter int WIDTH = GDIO_WIDTH_DEF
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] sample_r
);
	logic [WIDTH-1:0] hold_lat;

	// Keeps the level seen when the high phase closes, like the high-phase latch,
	// so the rising-edge flop never races the latch opening
	always_ff @(negedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hold_lat <= {WIDTH{GDIO_SAMPLE_RST}};
		end else begin
			hold_lat <= level_in;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sample_r <= {WIDTH{GDIO_SAMPLE_RST}};
		end else begin
			sample_r <= hold_lat;
		end
	end
endmodule

// File: hdl/gdio_pad.sv
/*
 * Pad control of one pin: direction, drive, pull-up and input enable,
 * with alternate-function overrides. Assumes registers come from the port.
 */
`timescale 1ns/1ns
module gdio_pad (
	input wire logic nrst,
	input wire logic dir_bit,
	input wire logic latch_bit,
	input wire logic pullup_off,
	input wire logic sleep,
	input wire logic ext_int_en,
	input wire logic alt_pu_oe,
	input wire logic alt_pu_ov,
	input wire logic alt_dir_oe,
	input wire logic alt_dir_ov,
	input wire logic alt_val_oe,
	input wire logic alt_val_ov,
	input wire logic alt_die_oe,
	input wire logic alt_die_ov,
	output logic drive_en,
	output logic drive_val,
	output logic pullup_en,
	output logic input_en
);
	wire dir_eff = alt_dir_oe ? alt_dir_ov : dir_bit;
	wire pu_plain = !dir_bit && latch_bit && !pullup_off;
	wire pu_eff = alt_pu_oe ? alt_pu_ov : pu_plain;
	wire clamp = sleep && !ext_int_en;

	// Reset tri-states without a clock
	assign drive_en = nrst && dir_eff;
	assign drive_val = alt_val_oe ? alt_val_ov : latch_bit;
	assign pullup_en = nrst && pu_eff;
	assign input_en = alt_die_oe ? alt_die_ov : !clamp;
endmodule

// File: hdl/gdio_port.sv
/*
 * General digital I/O port: direction, output latch and input sample
 * registers, toggle on sample write, single-bit set and clear.
 * Assumes a host driving one-cycle write strobes on clk_sys and
 * an external wire resolving pin level from drive and pull-up.
 */
`timescale 1ns/1ns
// Notes on behaviour
// R1: Direction bit one drives the pin; zero makes it an input.
// R2: Input with latch one and pull-ups allowed enables the pull-up.
// R3: Global pull-up disable switches off every pull-up; a pin with alt_pu_oe set keeps alt_pu_ov.
// R4: Output pin drives the latch value.
// R5: Reset tri-states every pin with no clock needed.
// R6: Writing one to a sample bit inverts that latch bit.
// R7: Sample bit shows the synchronised pin level in any direction.
// R8: Synchroniser is a falling-edge flop, standing in for a high-phase latch, followed by a rising-edge flop.
// R9: Pin edges reach the sample bit after half to one and a half periods.
// R10: Software-written value reads back one clock later; host waits a cycle.
// R11: Host passes through pull-up or output low between tri-state and high.
// R12: Host passes through tri-state or output high between pull-up and low.
// R13: Single-bit set or clear touches only the addressed pin.
// R14: Three separately selected registers: latch, direction, sample.
// R15: Sample is read-only; latch and direction are read and write.
// R16: Alternate functions on some pins leave the others unaffected.
// R17: Sleep clamps inputs low except interrupt or override pins.
// R18: Width is a parameter; direction and latch clear on reset.
module gdio_port
	import gdio_pkg::*;
#(
	parameter int WIDTH = GDIO_WIDTH_DEF,
	parameter int IDX_W = GDIO_IDX_W_DEF
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic wr_en,
	input wire gdio_reg_t wr_sel,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic bit_op_en,
	input wire gdio_reg_t bit_op_sel,
	input wire logic [IDX_W-1:0] bit_op_idx,
	input wire logic bit_op_set,
	input wire logic global_pullup_disable,
	input wire logic sleep,
	input wire logic [WIDTH-1:0] ext_int_en,
	input wire logic [WIDTH-1:0] alt_pu_oe,
	input wire logic [WIDTH-1:0] alt_pu_ov,
	input wire logic [WIDTH-1:0] alt_dir_oe,
	input wire logic [WIDTH-1:0] alt_dir_ov,
	input wire logic [WIDTH-1:0] alt_val_oe,
	input wire logic [WIDTH-1:0] alt_val_ov,
	input wire logic [WIDTH-1:0] alt_die_oe,
	input wire logic [WIDTH-1:0] alt_die_ov,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	output logic [WIDTH-1:0] pin_pullup_en,
	output logic [WIDTH-1:0] pin_input_sample_bit,
	output logic [WIDTH-1:0] direction_register,
	output logic [WIDTH-1:0] output_latch_register,
	output logic [WIDTH-1:0] input_sample_register
);
	logic [WIDTH-1:0] dir_r;
	logic [WIDTH-1:0] dir_nxt;
	logic [WIDTH-1:0] latch_r;
	logic [WIDTH-1:0] latch_nxt;
	logic [WIDTH-1:0] sample_r;
	logic [WIDTH-1:0] input_en;
	logic [WIDTH-1:0] drive_val;

	// Register select decode
	wire wr_dir = wr_en && (wr_sel == GDIO_REG_DIR); // R14
	wire wr_latch = wr_en && (wr_sel == GDIO_REG_LATCH); // R14
	wire wr_sample = wr_en && (wr_sel == GDIO_REG_SAMPLE); // R6

	// Single-bit operation mask
	wire [WIDTH-1:0] bit_mask = {{(WIDTH-1){1'b0}}, 1'b1} << bit_op_idx;
	wire bop_dir = bit_op_en && (bit_op_sel == GDIO_REG_DIR);
	wire bop_latch = bit_op_en && (bit_op_sel == GDIO_REG_LATCH);
	wire bop_sample = bit_op_en && (bit_op_sel == GDIO_REG_SAMPLE);

	// Direction next value
	wire [WIDTH-1:0] dir_bitop = bit_op_set ? (dir_r | bit_mask) : (dir_r & ~bit_mask); // R13
	wire [WIDTH-1:0] dir_word = wr_dir ? wr_data : dir_r;
	assign dir_nxt = bop_dir ? dir_bitop : dir_word;

	// Latch next value: plain write, bit op, then toggle
	wire [WIDTH-1:0] latch_bitop = bit_op_set ? (latch_r | bit_mask) : (latch_r & ~bit_mask); // R13
	wire [WIDTH-1:0] latch_word = wr_latch ? wr_data : latch_r;
	wire [WIDTH-1:0] latch_base = bop_latch ? latch_bitop : latch_word;
	wire [WIDTH-1:0] tog_word = wr_sample ? wr_data : {WIDTH{1'b0}}; // R6
	wire [WIDTH-1:0] tog_bit = (bop_sample && bit_op_set) ? bit_mask : {WIDTH{1'b0}}; // R6
	assign latch_nxt = latch_base ^ tog_word ^ tog_bit; // R6

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dir_r <= {WIDTH{GDIO_DIR_RST}}; // R18
			latch_r <= {WIDTH{GDIO_LATCH_RST}}; // R18
		end else begin
			dir_r <= dir_nxt;
			latch_r <= latch_nxt;
		end
	end

	// Per-pin pad control
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_pin
			gdio_pad u_pad (
				.nrst(nrst), // R5
				.dir_bit(dir_r[gi]), // R1
				.latch_bit(latch_r[gi]), // R4
				.pullup_off(global_pullup_disable), // R3
				.sleep(sleep), // R17
				.ext_int_en(ext_int_en[gi]), // R17
				.alt_pu_oe(alt_pu_oe[gi]), // R16
				.alt_pu_ov(alt_pu_ov[gi]),
				.alt_dir_oe(alt_dir_oe[gi]),
				.alt_dir_ov(alt_dir_ov[gi]),
				.alt_val_oe(alt_val_oe[gi]),
				.alt_val_ov(alt_val_ov[gi]),
				.alt_die_oe(alt_die_oe[gi]),
				.alt_die_ov(alt_die_ov[gi]),
				.drive_en(pin_oe[gi]),
				.drive_val(drive_val[gi]),
				.pullup_en(pin_pullup_en[gi]), // R2
				.input_en(input_en[gi])
			);
		end
	endgenerate

	// Clamped input seen by the synchroniser
	wire [WIDTH-1:0] pin_level = pin_in & input_en; // R17

	gdio_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.level_in(pin_level), // R7 R8 R9
		.sample_r(sample_r)
	);

	// Outputs
	assign pin_out = drive_val; // R4
	assign pin_input_sample_bit = sample_r; // R7
	assign direction_register = dir_r; // R15
	assign output_latch_register = latch_r; // R15
	assign input_sample_register = sample_r; // R15

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	wire no_alt_dir = (alt_dir_oe == {WIDTH{1'b0}});
	wire no_alt_pu = (alt_pu_oe == {WIDTH{1'b0}});
	wire no_alt_val = (alt_val_oe == {WIDTH{1'b0}});
	wire any_reg_op = wr_en || bit_op_en;

	chk_dir_drive: assert property ( // R1
		no_alt_dir |-> (pin_oe == dir_r)
	) else $error("Pin drive enable differs from direction");

	chk_pullup_enable: assert property ( // R2
		(no_alt_pu && !global_pullup_disable) |-> (pin_pullup_en == (latch_r & ~dir_r))
	) else $error("Pull-up enable wrong for latch and direction");

	chk_pullup_global_off: assert property ( // R3
		(no_alt_pu && global_pullup_disable) |-> (pin_pullup_en == {WIDTH{1'b0}})
	) else $error("Pull-up active while globally disabled");

	chk_drive_value: assert property ( // R4
		no_alt_val |-> (pin_out == latch_r)
	) else $error("Driven value differs from output latch");

	always_comb begin
		chk_reset_tristate: assert (nrst || (pin_oe == {WIDTH{1'b0}} && pin_pullup_en == {WIDTH{1'b0}})) // R5
		else $error("Pin driven or pulled during reset");
	end

	chk_toggle_write: assert property ( // R6
		(wr_sample && !bit_op_en) |=> (latch_r == ($past(latch_r) ^ $past(wr_data)))
	) else $error("Sample write did not toggle latch");

	chk_sync_follow: assert property ( // R7
		($stable(pin_level) ##1 $stable(pin_level)) |-> (sample_r == pin_level)
	) else $error("Sample does not follow a steady pin");

	chk_sync_delay: assert property ( // R9
		$changed(pin_level) ##1 $stable(pin_level) ##1 $stable(pin_level) |-> (sample_r == $past(pin_level, 1))
	) else $error("Pin change not sampled within the delay");

	chk_echo_latch: assert property ( // R10
		(dir_r[0] && no_alt_val && !any_reg_op && pin_in[0] == pin_out[0] && input_en[0])
		##1 ($stable(pin_in[0]) && !any_reg_op && input_en[0]) ##1 input_en[0]
		|-> (sample_r[0] == $past(latch_r[0], 2))
	) else $error("Written value not read back one clock later");

	chk_bitop_isolate: assert property ( // R13
		(bop_dir && !wr_en) |=> ((dir_r & ~$past(bit_mask)) == ($past(dir_r) & ~$past(bit_mask)))
	) else $error("Bit operation touched another pin");

	chk_bitop_value: assert property ( // R13
		(bop_latch && !wr_en) |=> ((latch_r & $past(bit_mask)) == ($past(bit_op_set) ? $past(bit_mask) : {WIDTH{1'b0}}))
	) else $error("Bit operation wrote the wrong value");

	chk_regs_hold: assert property ( // R15
		!any_reg_op |=> ($stable(dir_r) && $stable(latch_r))
	) else $error("Register changed without an access");

	chk_sleep_clamp: assert property ( // R17
		(sleep && (alt_die_oe == {WIDTH{1'b0}})) |-> ((input_en & ~ext_int_en) == {WIDTH{1'b0}})
	) else $error("Input not clamped in sleep");

	chk_alt_isolate: assert property ( // R16
		(alt_dir_oe[0] == 1'b0) |-> (pin_oe[0] == dir_r[0])
	) else $error("Override leaked into a plain pin");

	chk_reset_values: assert property ( // R18
		$rose(nrst) |-> (dir_r == {WIDTH{1'b0}} && latch_r == {WIDTH{1'b0}})
	) else $error("Registers not cleared by reset");

	cov_pullup_input: cover property (
		pin_pullup_en[0] ##1 !pin_pullup_en[0]
	);

	cov_toggle: cover property (
		wr_sample ##1 (latch_r != $past(latch_r))
	);

	cov_output_high: cover property (
		pin_oe[0] && pin_out[0] && sample_r[0]
	);

	cov_sleep_clamp: cover property (
		sleep && pin_in[0] && !input_en[0]
	);
endmodule

// File: bench/gdio_pins.sv
/*
 * Model of the wires outside the port pins: an external driver, the
 * port's own drivers and pull-ups. Assumes pad controls from gdio_port.
 */
`timescale 1ns/1ns
module gdio_pins
	import gdio_pkg::*;
#(
	parameter int WIDTH = GDIO_WIDTH_DEF
) (
	input wire logic clk_sys,
	input wire logic [WIDTH-1:0] pin_out,
	input wire logic [WIDTH-1:0] pin_oe,
	input wire logic [WIDTH-1:0] pin_pullup_en,
	input wire logic [WIDTH-1:0] ext_en,
	input wire logic [WIDTH-1:0] ext_val,
	output logic [WIDTH-1:0] pin_lvl
);
	logic [WIDTH-1:0] float_r = '0;
	// Undriven lines wander every cycle
	always @(posedge clk_sys) begin
		float_r <= ~float_r;
	end
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (ext_en[i])
				pin_lvl[i] = ext_val[i];
			else if (pin_oe[i])
				pin_lvl[i] = pin_out[i];
			else if (pin_pullup_en[i])
				pin_lvl[i] = 1'b1;
			else
				pin_lvl[i] = float_r[i];
		end
	end
endmodule

// File: bench/general_digital_io_port_test.sv
/*
 * Self-checking bench of gdio_port with the pin wire model.
 * Assumes the default width of eight pins.
 */
`timescale 1ns/1ns
module general_digital_io_port_test;
	import gdio_pkg::*;
	localparam int W = GDIO_WIDTH_DEF;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic wr_en = 1'b0, bit_op_en = 1'b0, bit_op_set = 1'b0, pullup_off = 1'b0, sleep = 1'b0;
	gdio_reg_t wr_sel = GDIO_REG_LATCH, bit_op_sel = GDIO_REG_LATCH;
	logic [2:0] bit_op_idx = 3'h0;
	logic [W-1:0] wr_data = '0, ext_int_en = '0, alt_m = '0, ext_en = '0, ext_val = '0;
	logic [W-1:0] pin_in, pin_out, pin_oe, pu_en, samp_bit, dir_q, latch_q, samp_q;
	int miscompares = 0;
	int n_compared = 0;

	gdio_port gdio_port_inst (.clk_sys(clk_sys), .nrst(nrst), .wr_en(wr_en), .wr_sel(wr_sel),
		.wr_data(wr_data), .bit_op_en(bit_op_en), .bit_op_sel(bit_op_sel), .bit_op_idx(bit_op_idx),
		.bit_op_set(bit_op_set), .global_pullup_disable(pullup_off), .sleep(sleep), .ext_int_en(ext_int_en),
		.alt_pu_oe(8'h00), .alt_pu_ov(8'h00), .alt_dir_oe(alt_m), .alt_dir_ov(alt_m),
		.alt_val_oe(alt_m), .alt_val_ov(8'h00), .alt_die_oe(8'h00), .alt_die_ov(8'h00),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu_en),
		.pin_input_sample_bit(samp_bit), .direction_register(dir_q),
		.output_latch_register(latch_q), .input_sample_register(samp_q));
	gdio_pins gdio_pins_inst (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup_en(pu_en), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic end_of_test();
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	// Word write, strobe for one edge then one idle edge
	task automatic wr(input gdio_reg_t sel, input logic [W-1:0] d);
		wr_en = 1'b1;
		wr_sel = sel;
		wr_data = d;
		tick();
		wr_en = 1'b0;
		tick();
	endtask

	// Single-bit set or clear
	task automatic bop(input gdio_reg_t sel, input logic [2:0] idx, input logic set);
		bit_op_en = 1'b1;
		bit_op_sel = sel;
		bit_op_idx = idx;
		bit_op_set = set;
		tick();
		bit_op_en = 1'b0;
		tick();
	endtask

	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (6) tick();
		chk(pin_oe, 8'h00);
		nrst = 1'b1;
		tick();
		chk(dir_q, 8'h00);
		chk(latch_q, 8'h00);
		ext_en = 8'hF0;
		ext_val = 8'hA0;
		// Tri-state to pull-up first, then to output high
		wr(GDIO_REG_LATCH, 8'h0F);
		chk(pu_en, 8'h0F);
		pullup_off = 1'b1;
		#1 chk(pu_en, 8'h00);
		tick();
		pullup_off = 1'b0;
		wr(GDIO_REG_DIR, 8'h03);
		chk(pin_oe, 8'h03);
		chk(pin_out & 8'h03, 8'h03);
		chk(pu_en, 8'h0C);
		chk(samp_q, 8'hAF);
		chk(samp_bit, 8'hAF);
		wr(GDIO_REG_SAMPLE, 8'h81);
		chk(latch_q, 8'h8E);
		wr(gdio_reg_t'(2'b11), 8'hFF);
		chk(latch_q, 8'h8E);
		chk(dir_q, 8'h03);
		ext_en = 8'h70;
		bop(GDIO_REG_DIR, 3'h7, 1'b1);
		chk(dir_q, 8'h83);
		bop(GDIO_REG_LATCH, 3'h1, 1'b0);
		chk(latch_q, 8'h8C);
		bop(GDIO_REG_SAMPLE, 3'h0, 1'b1);
		chk(latch_q, 8'h8D);
		bop(GDIO_REG_SAMPLE, 3'h2, 1'b0);
		chk(latch_q, 8'h8D);
		chk(samp_q, 8'hAD);
		// Pin change while the clock is low
		#5 ext_val = 8'hF0;
		tick();
		chk(samp_q, 8'hAD);
		tick();
		chk(samp_q, 8'hFD);
		ext_val = 8'hA0;
		tick();
		chk(samp_q, 8'hAD);
		alt_m = 8'h80;
		#1 chk(pin_oe, 8'h83);
		chk(pin_out, 8'h0D);
		chk(pu_en, 8'h0C);
		tick();
		alt_m = 8'h00;
		sleep = 1'b1;
		ext_int_en = 8'h20;
		tick();
		tick();
		chk(samp_q, 8'h20);
		sleep = 1'b0;
		// Reset between edges
		#2 nrst = 1'b0;
		#1 chk(pin_oe, 8'h00);
		chk(pu_en, 8'h00);
		chk(dir_q, 8'h00);
		tick();
		nrst = 1'b1;
		tick();
		end_of_test();
	end
endmodule
